// File: mbs_pkg.sv
// package: constants for the motor brake sequencer
`default_nettype none
package mbs_pkg;
	// brake enable codes
	localparam logic [1:0] ENABLE_OFF = 2'h0;
	localparam logic [1:0] ENABLE_ON  = 2'h1;
	// terminal function codes
	localparam logic [7:0] IN_FUNC_CONFIRM  = 8'h2C; // 44 decimal
	localparam logic [7:0] OUT_FUNC_RELEASE = 8'h13; // 19 decimal
	localparam logic [7:0] OUT_FUNC_ERROR   = 8'h14; // 20 decimal
	localparam int         NUM_IN_TERM      = 8;
	localparam int         NUM_OUT_TERM     = 5;
	// wait times in units of 10 ms, 0.00 .. 5.00 s
	localparam logic [8:0] WAIT_MAX     = 9'h1F4;
	localparam int         TICK_MS      = 10;
	localparam int         CLK_HZ       = 40_000_000;
	localparam int         TICK_CYCLES  = (CLK_HZ / 1000) * TICK_MS;
	// current threshold in percent of rated, up to 150
	localparam logic [7:0] CURRENT_MAX  = 8'h96;
	// frequency in 0.01 Hz units, up to 400.00 Hz
	localparam logic [15:0] FREQ_MAX    = 16'h9C40;
	// register map of the plain port
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_REL_WAIT = 4'h1;
	localparam logic [3:0] REG_ACC_WAIT = 4'h2;
	localparam logic [3:0] REG_STP_WAIT = 4'h3;
	localparam logic [3:0] REG_CNF_WAIT = 4'h4;
	localparam logic [3:0] REG_REL_FREQ = 4'h5;
	localparam logic [3:0] REG_REL_CUR  = 4'h6;
	localparam logic [3:0] REG_APP_FREQ = 4'h7;
	localparam logic [3:0] REG_IN_FUNC  = 4'h8;
	localparam logic [3:0] REG_OUT_FUNC = 4'h9;
	localparam logic [3:0] REG_STATUS   = 4'hA;
	localparam logic [3:0] REG_IRQ_STAT = 4'hB;
	localparam logic [3:0] REG_IRQ_MASK = 4'hC;
	// interrupt status bits
	localparam int IRQ_RELEASE = 0;
	localparam int IRQ_APPLY   = 1;
	localparam int IRQ_TRIP    = 2;
	localparam int IRQ_DONE    = 3;
	localparam int IRQ_W       = 4;
	// trip causes
	localparam logic [1:0] CAUSE_NONE    = 2'h0;
	localparam logic [1:0] CAUSE_CURRENT = 2'h1;
	localparam logic [1:0] CAUSE_CONFIRM = 2'h2;
	localparam logic [1:0] CAUSE_DROP    = 2'h3;
	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_RAMP_UP = 9'h002,
		ST_REL_WT  = 9'h004,
		ST_CNF_ON  = 9'h008,
		ST_ACC_WT  = 9'h010,
		ST_RUN     = 9'h020,
		ST_RAMP_DN = 9'h040,
		ST_CNF_OFF = 9'h080,
		ST_STP_WT  = 9'h100
	} mbs_state_type;
endpackage
`default_nettype wire

// File: mbs_wait_timer.sv
// wait timer: counts 10 ms ticks up to a loaded limit
`timescale 1ns/1ps
`default_nettype none
module mbs_wait_timer #(
	parameter int TICK_CYCLES = mbs_pkg::TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic [8:0] limit,
	output logic            done
);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	logic [CW-1:0] pre_q;
	logic [8:0]    cnt_q;
	logic          run_q;
	logic          tick;

	assign tick = (pre_q == CW'(TICK_CYCLES - 1));
	// done is a level while the count has reached the limit
	assign done = run_q && (cnt_q >= limit);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
		end else if (start || tick) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + CW'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (start) begin
			cnt_q <= '0;
			run_q <= 1'b1;
		end else if (tick && run_q && (cnt_q < limit)) begin
			cnt_q <= cnt_q + 9'h001;
		end
	end
endmodule
`default_nettype wire

// File: mbs_motor_brake_sequencer.sv
// motor brake sequencer: state machine, register port, terminal mapping
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sequence runs only when enable setting is 01; 00 disables it
// - run command ramps up to release frequency, then holds
// - at release frequency wait release time, then assert release output
// - current below threshold after release wait: no release, trip, error
// - confirm input assigned (44): hold, trip if confirm late
// - no confirm input assigned: skip confirm wait entirely
// - after confirm or release, wait accel time then ramp to command
// - run removed: decelerate to braking frequency, then drop release
// - confirm assigned: hold until confirm off, trip if it stays on
// - after confirm clears or release drops, wait stop time, go to zero
// - confirm dropping while release asserted trips with brake error
// - release output is function 19, error output function 20
// - four wait times configurable 0.00 to 5.00 seconds
// - release current threshold 0 to 1.50 times rated gates release
module mbs_motor_brake_sequencer #(
	parameter int TICK_CYCLES = mbs_pkg::TICK_CYCLES,
	parameter int NUM_IN      = mbs_pkg::NUM_IN_TERM,
	parameter int NUM_OUT     = mbs_pkg::NUM_OUT_TERM
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [3:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic [31:0]             reg_rdata,
	input  wire logic               run_cmd,
	input  wire logic [15:0]        command_frequency,
	input  wire logic [15:0]        output_frequency,
	input  wire logic [7:0]         output_current,
	input  wire logic [NUM_IN-1:0]  input_terminals,
	output logic [15:0]             target_frequency,
	output logic                    output_enable,
	output logic                    brake_release_out,
	output logic                    brake_error_out,
	output logic                    brake_fault_trip,
	output logic [NUM_OUT-1:0]      output_terminals,
	output logic                    irq
);
	// ****************************************
	// configuration registers
	// ****************************************
	logic [1:0]  brake_seq_enable_q;
	logic [8:0]  release_wait_time_q;
	logic [8:0]  accel_wait_time_q;
	logic [8:0]  stop_wait_time_q;
	logic [8:0]  confirm_wait_time_q;
	logic [15:0] release_frequency_q;
	logic [7:0]  release_current_q;
	logic [15:0] apply_frequency_q;
	logic [7:0]  in_func_q [NUM_IN];
	logic [7:0]  out_func_q [NUM_OUT];
	logic [mbs_pkg::IRQ_W-1:0] irq_stat_q;
	logic [mbs_pkg::IRQ_W-1:0] irq_mask_q;
	logic [mbs_pkg::IRQ_W-1:0] irq_event;
	logic [1:0]  trip_cause_q;
	logic [1:0]  trip_cause_d;
	mbs_pkg::mbs_state_type state_q;
	mbs_pkg::mbs_state_type state_d;

	function automatic logic [8:0] clamp_wait(input logic [31:0] v);
		clamp_wait = (v[15:0] > 16'(mbs_pkg::WAIT_MAX)) ? mbs_pkg::WAIT_MAX : v[8:0];
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brake_seq_enable_q  <= mbs_pkg::ENABLE_OFF;
			release_wait_time_q <= '0;
			accel_wait_time_q   <= '0;
			stop_wait_time_q    <= '0;
			confirm_wait_time_q <= '0;
			release_frequency_q <= '0;
			release_current_q   <= '0;
			apply_frequency_q   <= '0;
			irq_mask_q          <= '0;
		end else if (reg_write) begin
			unique case (reg_addr)
				mbs_pkg::REG_CTRL:     brake_seq_enable_q  <= reg_wdata[1:0];
				mbs_pkg::REG_REL_WAIT: release_wait_time_q <= clamp_wait(reg_wdata);
				mbs_pkg::REG_ACC_WAIT: accel_wait_time_q   <= clamp_wait(reg_wdata);
				mbs_pkg::REG_STP_WAIT: stop_wait_time_q    <= clamp_wait(reg_wdata);
				mbs_pkg::REG_CNF_WAIT: confirm_wait_time_q <= clamp_wait(reg_wdata);
				mbs_pkg::REG_REL_FREQ: release_frequency_q <= (reg_wdata[15:0] > mbs_pkg::FREQ_MAX)
					? mbs_pkg::FREQ_MAX : reg_wdata[15:0];
				mbs_pkg::REG_REL_CUR:  release_current_q   <= (reg_wdata[7:0] > mbs_pkg::CURRENT_MAX)
					? mbs_pkg::CURRENT_MAX : reg_wdata[7:0];
				mbs_pkg::REG_APP_FREQ: apply_frequency_q   <= (reg_wdata[15:0] > mbs_pkg::FREQ_MAX)
					? mbs_pkg::FREQ_MAX : reg_wdata[15:0];
				mbs_pkg::REG_IRQ_MASK: irq_mask_q          <= reg_wdata[mbs_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// terminal function tables: one byte per terminal, one word of four bytes, terminal n takes byte n mod 4
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_in
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					in_func_q[gi] <= '0;
				end else if (reg_write && reg_addr == mbs_pkg::REG_IN_FUNC) begin
					in_func_q[gi] <= reg_wdata[(gi%4)*8 +: 8];
				end
			end
		end
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					out_func_q[gi] <= '0;
				end else if (reg_write && reg_addr == mbs_pkg::REG_OUT_FUNC) begin
					out_func_q[gi] <= reg_wdata[(gi%4)*8 +: 8];
				end
			end
			always_comb begin
				unique case (out_func_q[gi])
					mbs_pkg::OUT_FUNC_RELEASE: output_terminals[gi] = brake_release_out;
					mbs_pkg::OUT_FUNC_ERROR:   output_terminals[gi] = brake_error_out;
					default:                   output_terminals[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	// ****************************************
	// confirm input selection
	// ****************************************
	logic confirm_assigned;
	logic confirm_in;
	always_comb begin
		confirm_assigned = 1'b0;
		confirm_in       = 1'b0;
		for (int i = 0; i < NUM_IN; i++) begin
			if (in_func_q[i] == mbs_pkg::IN_FUNC_CONFIRM) begin
				confirm_assigned = 1'b1;
				confirm_in       = confirm_in | input_terminals[i];
			end
		end
	end
	logic brake_confirm_in;
	assign brake_confirm_in = confirm_in;

	// ****************************************
	// sequencer
	// ****************************************
	logic       enabled;
	logic       tmr_start;
	logic [8:0] tmr_limit;
	logic       tmr_done;
	logic       trip_d;
	assign enabled = (brake_seq_enable_q == mbs_pkg::ENABLE_ON);

	mbs_wait_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.clk   (clk),
		.rst   (rst),
		.start (tmr_start),
		.limit (tmr_limit),
		.done  (tmr_done)
	);

	always_comb begin
		state_d      = state_q;
		tmr_start    = 1'b0;
		tmr_limit    = release_wait_time_q;
		trip_d       = 1'b0;
		trip_cause_d = mbs_pkg::CAUSE_NONE;
		unique case (state_q)
			mbs_pkg::ST_IDLE: begin
				if (run_cmd && enabled && !brake_fault_trip) begin
					state_d = mbs_pkg::ST_RAMP_UP;
				end
			end
			mbs_pkg::ST_RAMP_UP: begin
				if (output_frequency >= release_frequency_q) begin
					state_d   = mbs_pkg::ST_REL_WT;
					tmr_start = 1'b1;
				end
			end
			mbs_pkg::ST_REL_WT: begin
				tmr_limit = release_wait_time_q;
				if (tmr_done) begin
					if (output_current < release_current_q) begin
						trip_d       = 1'b1;
						trip_cause_d = mbs_pkg::CAUSE_CURRENT;
						state_d      = mbs_pkg::ST_IDLE;
					end else begin
						tmr_start = 1'b1;
						state_d   = confirm_assigned ? mbs_pkg::ST_CNF_ON
							: mbs_pkg::ST_ACC_WT;
					end
				end
			end
			mbs_pkg::ST_CNF_ON: begin
				tmr_limit = confirm_wait_time_q;
				if (brake_confirm_in) begin
					tmr_start = 1'b1;
					state_d   = mbs_pkg::ST_ACC_WT;
				end else if (tmr_done) begin
					trip_d       = 1'b1;
					trip_cause_d = mbs_pkg::CAUSE_CONFIRM;
					state_d      = mbs_pkg::ST_IDLE;
				end
			end
			mbs_pkg::ST_ACC_WT: begin
				tmr_limit = accel_wait_time_q;
				if (tmr_done) begin
					state_d = mbs_pkg::ST_RUN;
				end
			end
			mbs_pkg::ST_RUN: begin
				if (!run_cmd) begin
					state_d = mbs_pkg::ST_RAMP_DN;
				end
			end
			mbs_pkg::ST_RAMP_DN: begin
				if (output_frequency <= apply_frequency_q) begin
					tmr_start = 1'b1;
					state_d   = confirm_assigned ? mbs_pkg::ST_CNF_OFF
						: mbs_pkg::ST_STP_WT;
				end
			end
			mbs_pkg::ST_CNF_OFF: begin
				tmr_limit = confirm_wait_time_q;
				if (!brake_confirm_in) begin
					tmr_start = 1'b1;
					state_d   = mbs_pkg::ST_STP_WT;
				end else if (tmr_done) begin
					trip_d       = 1'b1;
					trip_cause_d = mbs_pkg::CAUSE_CONFIRM;
					state_d      = mbs_pkg::ST_IDLE;
				end
			end
			mbs_pkg::ST_STP_WT: begin
				tmr_limit = stop_wait_time_q;
				if (tmr_done) begin
					state_d = mbs_pkg::ST_IDLE;
				end
			end
			default: state_d = mbs_pkg::ST_IDLE;
		endcase
		// release held with confirm assigned: losing confirm is a fault
		if (brake_release_out && confirm_assigned && !brake_confirm_in
			&& state_q != mbs_pkg::ST_CNF_ON) begin
			trip_d       = 1'b1;
			trip_cause_d = mbs_pkg::CAUSE_DROP;
			state_d      = mbs_pkg::ST_IDLE;
		end
		// disabling mid-sequence drops back to idle
		if (!enabled) begin
			state_d = mbs_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= mbs_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// trip stays latched; only reset clears it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brake_fault_trip <= 1'b0;
			trip_cause_q     <= mbs_pkg::CAUSE_NONE;
		end else if (trip_d && !brake_fault_trip) begin
			brake_fault_trip <= 1'b1;
			trip_cause_q     <= trip_cause_d;
		end
	end
	assign brake_error_out = brake_fault_trip;

	// release is a flop so it never glitches on the terminal
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brake_release_out <= 1'b0;
		end else begin
			brake_release_out <= !trip_d && (state_d == mbs_pkg::ST_CNF_ON
				|| state_d == mbs_pkg::ST_ACC_WT || state_d == mbs_pkg::ST_RUN
				|| state_d == mbs_pkg::ST_RAMP_DN);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			target_frequency <= '0;
			output_enable    <= 1'b0;
		end else begin
			output_enable <= (state_d != mbs_pkg::ST_IDLE) && !trip_d;
			unique case (state_d)
				mbs_pkg::ST_RUN:     target_frequency <= command_frequency;
				mbs_pkg::ST_RAMP_DN: target_frequency <= apply_frequency_q;
				mbs_pkg::ST_CNF_OFF: target_frequency <= apply_frequency_q;
				mbs_pkg::ST_STP_WT:  target_frequency <= apply_frequency_q;
				mbs_pkg::ST_IDLE:    target_frequency <= '0;
				default:             target_frequency <= release_frequency_q;
			endcase
		end
	end

	// ****************************************
	// interrupts and read port
	// ****************************************
	assign irq_event[mbs_pkg::IRQ_RELEASE] = brake_release_out == 1'b0 && state_d == mbs_pkg::ST_CNF_ON
		|| (!brake_release_out && state_d == mbs_pkg::ST_ACC_WT && state_q == mbs_pkg::ST_REL_WT);
	assign irq_event[mbs_pkg::IRQ_APPLY]   = brake_release_out && state_q == mbs_pkg::ST_RAMP_DN
		&& state_d != mbs_pkg::ST_RAMP_DN;
	assign irq_event[mbs_pkg::IRQ_TRIP]    = trip_d && !brake_fault_trip;
	assign irq_event[mbs_pkg::IRQ_DONE]    = state_q == mbs_pkg::ST_STP_WT && state_d == mbs_pkg::ST_IDLE;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((reg_write && reg_addr == mbs_pkg::REG_IRQ_STAT)
				? reg_wdata[mbs_pkg::IRQ_W-1:0] : '0)) | irq_event;
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			unique case (reg_addr)
				mbs_pkg::REG_CTRL:     reg_rdata <= {30'h0, brake_seq_enable_q};
				mbs_pkg::REG_REL_WAIT: reg_rdata <= {23'h0, release_wait_time_q};
				mbs_pkg::REG_ACC_WAIT: reg_rdata <= {23'h0, accel_wait_time_q};
				mbs_pkg::REG_STP_WAIT: reg_rdata <= {23'h0, stop_wait_time_q};
				mbs_pkg::REG_CNF_WAIT: reg_rdata <= {23'h0, confirm_wait_time_q};
				mbs_pkg::REG_REL_FREQ: reg_rdata <= {16'h0, release_frequency_q};
				mbs_pkg::REG_REL_CUR:  reg_rdata <= {24'h0, release_current_q};
				mbs_pkg::REG_APP_FREQ: reg_rdata <= {16'h0, apply_frequency_q};
				mbs_pkg::REG_IN_FUNC:  reg_rdata <= {in_func_q[3], in_func_q[2], in_func_q[1], in_func_q[0]};
				mbs_pkg::REG_OUT_FUNC: reg_rdata <= {out_func_q[3], out_func_q[2], out_func_q[1], out_func_q[0]};
				mbs_pkg::REG_STATUS:   reg_rdata <= {17'h0, trip_cause_q, brake_fault_trip,
					brake_release_out, brake_confirm_in, confirm_assigned, state_q};
				mbs_pkg::REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_q};
				mbs_pkg::REG_IRQ_MASK: reg_rdata <= {28'h0, irq_mask_q};
				default:               reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule
`default_nettype wire

// File: mbs_seq_chk.sv
// checker: port-level properties of the motor brake sequencer
`timescale 1ns/1ps
`default_nettype none
module mbs_seq_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        run_cmd,
	input wire logic [15:0] output_frequency,
	input wire logic [15:0] target_frequency,
	input wire logic        output_enable,
	input wire logic        brake_release_out,
	input wire logic        brake_error_out,
	input wire logic        brake_fault_trip
);
	// ****
	// brake release and trip properties
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence rel_rise;
		$rose(brake_release_out);
	endsequence
	sequence normal_drop;
		$fell(brake_release_out) && !brake_fault_trip;
	endsequence
	trip_stays_latched_a: assert property (brake_fault_trip |=> brake_fault_trip)
		else $error("trip flag cleared without reset");
	error_follows_trip_a: assert property (brake_error_out == brake_fault_trip)
		else $error("error output differs from trip flag");
	trip_closes_brake_a: assert property (brake_fault_trip |-> !brake_release_out)
		else $error("release output high while tripped");
	release_needs_run_a: assert property (brake_release_out |-> output_enable)
		else $error("release output high with output stopped");
	start_closed_a: assert property ($rose(output_enable) |-> (!brake_release_out) [*2])
		else $error("release output at start of output");
	release_at_freq_a: assert property (rel_rise |->
		$past(output_frequency) >= $past(target_frequency))
		else $error("release before release frequency reached");
	release_holds_a: assert property (rel_rise |-> $stable(target_frequency))
		else $error("ramp target moved as release rose");
	drop_after_stop_a: assert property (normal_drop |-> !$past(run_cmd))
		else $error("release dropped while run command held");
	zero_at_end_a: assert property ($fell(output_enable) && !brake_fault_trip |->
		target_frequency == 16'h0000)
		else $error("output stopped with nonzero target");
endmodule
bind mbs_motor_brake_sequencer mbs_seq_chk i_chk (
	.clk(clk), .rst(rst), .run_cmd(run_cmd), .output_frequency(output_frequency),
	.target_frequency(target_frequency), .output_enable(output_enable),
	.brake_release_out(brake_release_out), .brake_error_out(brake_error_out),
	.brake_fault_trip(brake_fault_trip)
);
`default_nettype wire

// File: mbs_brake_model.sv
// brake model: mechanical brake with a release confirmation contact
`timescale 1ns/1ps
`default_nettype none
module mbs_brake_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       release_cmd,
	input  wire logic [7:0] delay,
	input  wire logic [1:0] fault,
	output logic            confirm
);
	// ****
	// contact follows the release command after a mechanical delay
	// ****
	// fault 1 holds the contact open, fault 2 welds it closed
	logic [7:0] cnt_q;
	logic       contact_q;
	assign confirm = contact_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q     <= 8'h00;
			contact_q <= 1'b0;
		end else if (fault == 2'h1) begin
			contact_q <= 1'b0;
		end else if (fault == 2'h2) begin
			contact_q <= 1'b1;
		end else if (release_cmd == contact_q) begin
			cnt_q <= 8'h00;
		end else if (cnt_q >= delay) begin
			cnt_q     <= 8'h00;
			contact_q <= release_cmd;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: mbs_motor_brake_sequencer_tb.sv
// testbench: register port, brake sequence and trip scenarios
`timescale 1ns/1ps
`default_nettype none
module mbs_motor_brake_sequencer_tb;
	// ****
	// setup: short tick so waits span a few cycles
	// ****
	localparam int          TC  = 4;
	localparam int          RW  = 2;
	localparam int          AW  = 3;
	localparam int          SW  = 2;
	localparam int          CW  = 6;
	localparam logic [15:0] REL = 16'h01F4;
	localparam logic [15:0] APP = 16'h012C;
	localparam logic [15:0] CMD = 16'h1388;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic        run_cmd = 1'b0;
	logic [15:0] output_frequency = 16'h0000;
	logic [7:0]  output_current = 8'h64;
	logic [7:0]  brake_delay = 8'h03;
	logic [1:0]  fault = 2'h0;
	logic        confirm;
	logic [15:0] target_frequency;
	logic        output_enable, brake_release_out, brake_error_out, brake_fault_trip, irq;
	logic [4:0]  output_terminals;
	int          failures = 0;
	int          checks_done = 0;
	always #12.5 clk = ~clk;
	// ramp stands in for the drive: it reaches any target one cycle later
	always @(posedge clk) begin
		output_frequency <= target_frequency;
	end
	mbs_motor_brake_sequencer #(.TICK_CYCLES(TC)) i_dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.run_cmd(run_cmd), .command_frequency(CMD), .output_frequency(output_frequency),
		.output_current(output_current), .input_terminals({1'b0, confirm, 3'b000, confirm, 2'b00}),
		.target_frequency(target_frequency), .output_enable(output_enable),
		.brake_release_out(brake_release_out), .brake_error_out(brake_error_out),
		.brake_fault_trip(brake_fault_trip), .output_terminals(output_terminals), .irq(irq));
	mbs_brake_model i_brake (.clk(clk), .rst(rst), .release_cmd(brake_release_out),
		.delay(brake_delay), .fault(fault), .confirm(confirm));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk("rdata", e, reg_rdata);
	endtask
	function automatic logic cond(input int k);
		case (k)
			0: return brake_release_out === 1'b1;
			1: return brake_release_out === 1'b0;
			2: return brake_fault_trip === 1'b1;
			3: return target_frequency === CMD;
			4: return target_frequency === 16'h0000;
			5: return target_frequency === REL;
			default: return target_frequency === APP;
		endcase
	endfunction
	task automatic waitc(input int k, input int lo, input int hi);
		int n;
		n = 0;
		while (!cond(k) && n <= hi) begin
			@(posedge clk);
			#1;
			n++;
		end
		checks_done++;
		if (n < lo || n > hi) begin
			failures++;
			$display("unexpected wait %0d: expected %0d..%0d cycles, seen %0d", k, lo, hi, n);
		end
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst            <= 1'b1;
		run_cmd        <= 1'b0;
		fault          <= 2'h0;
		output_current <= 8'h64;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic cfg(input logic a);
		wr(mbs_pkg::REG_CTRL, 32'h0000_0001);
		wr(mbs_pkg::REG_REL_WAIT, RW);
		wr(mbs_pkg::REG_ACC_WAIT, AW);
		wr(mbs_pkg::REG_STP_WAIT, SW);
		wr(mbs_pkg::REG_CNF_WAIT, CW);
		wr(mbs_pkg::REG_REL_FREQ, {16'h0000, REL});
		wr(mbs_pkg::REG_REL_CUR, 32'h0000_0032);
		wr(mbs_pkg::REG_APP_FREQ, {16'h0000, APP});
		wr(mbs_pkg::REG_IN_FUNC, a ? 32'h002C_0000 : 32'h0000_0000);
		wr(mbs_pkg::REG_OUT_FUNC, 32'h0000_1413);
		wr(mbs_pkg::REG_IRQ_MASK, 32'h0000_0005);
	endtask
	// ****
	// scenarios
	// ****
	task automatic s_regs();
		rd(mbs_pkg::REG_CTRL, 32'h0000_0000);
		rd(mbs_pkg::REG_IRQ_MASK, 32'h0000_0000);
		wr(mbs_pkg::REG_REL_WAIT, 32'h0000_03FF);
		rd(mbs_pkg::REG_REL_WAIT, 32'h0000_01F4);
		wr(mbs_pkg::REG_ACC_WAIT, 32'h0000_0000);
		rd(mbs_pkg::REG_ACC_WAIT, 32'h0000_0000);
		wr(mbs_pkg::REG_REL_CUR, 32'h0000_00FF);
		rd(mbs_pkg::REG_REL_CUR, 32'h0000_0096);
		wr(mbs_pkg::REG_REL_FREQ, 32'h0000_FFFF);
		rd(mbs_pkg::REG_REL_FREQ, 32'h0000_9C40);
		wr(4'hF, 32'h0000_1234);
		rd(4'hF, 32'h0000_0000);
	endtask
	task automatic s_disabled();
		for (int en = 0; en < 4; en += 2) begin
			do_reset();
			cfg(1'b0);
			wr(mbs_pkg::REG_CTRL, en);
			run_cmd <= 1'b1;
			repeat (60) @(posedge clk);
			#1;
			chk("release", 0, brake_release_out);
			chk("enable", 0, output_enable);
		end
	endtask
	task automatic s_cycle(input logic a, input int d);
		do_reset();
		cfg(a);
		brake_delay <= d[7:0];
		fault       <= a ? 2'h0 : 2'h1;
		@(posedge clk);
		run_cmd <= 1'b1;
		#1;
		waitc(5, 0, 3);
		chk("enable", 1, output_enable);
		waitc(0, (RW - 1) * TC, (RW + 1) * TC + 6);
		chk("term0", 1, output_terminals[0]);
		waitc(3, (AW - 1) * TC + (a ? d : 0), (AW + 1) * TC + 8 + (a ? d : 0));
		chk("irq", 1, irq);
		wr(mbs_pkg::REG_IRQ_STAT, 32'h0000_0001);
		@(posedge clk);
		#1;
		chk("irq", 0, irq);
		@(posedge clk);
		run_cmd <= 1'b0;
		#1;
		waitc(6, 0, 3);
		waitc(1, 0, 6);
		waitc(4, (SW - 1) * TC + (a ? d : 0), (SW + 1) * TC + 8 + (a ? d : 0));
		chk("trip", 0, brake_fault_trip);
	endtask
	task automatic s_trip_current();
		do_reset();
		cfg(1'b0);
		output_current <= 8'h0A;
		@(posedge clk);
		run_cmd <= 1'b1;
		#1;
		waitc(2, (RW - 1) * TC, (RW + 1) * TC + 8);
		chk("release", 0, brake_release_out);
		chk("term1", 1, output_terminals[1]);
		chk("irq", 1, irq);
		@(posedge clk);
		run_cmd <= 1'b0;
		repeat (50) @(posedge clk);
		#1;
		chk("trip", 1, brake_fault_trip);
		rd(mbs_pkg::REG_STATUS, 32'h0000_3001);
		do_reset();
		#1;
		chk("trip", 0, brake_fault_trip);
	endtask
	task automatic s_brake_fault(input int mode);
		do_reset();
		cfg(1'b1);
		fault <= (mode == 0) ? 2'h1 : 2'h0;
		@(posedge clk);
		run_cmd <= 1'b1;
		#1;
		waitc(0, 0, 40);
		if (mode == 0) begin
			waitc(2, (CW - 1) * TC, (CW + 1) * TC + 6);
		end else begin
			waitc(3, 0, 60);
			@(posedge clk);
			fault <= (mode == 1) ? 2'h2 : 2'h1;
			if (mode == 1) begin
				run_cmd <= 1'b0;
				#1;
				waitc(1, 0, 8);
				waitc(2, (CW - 1) * TC, (CW + 1) * TC + 8);
			end else begin
				#1;
				waitc(2, 0, 4);
			end
		end
		chk("release", 0, brake_release_out);
		chk("error", 1, brake_error_out);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		do_reset();
		s_regs();
		s_disabled();
		s_cycle(1'b0, 3);
		s_cycle(1'b1, 3);
		s_cycle(1'b1, 12);
		s_trip_current();
		for (int m = 0; m < 3; m++) begin
			s_brake_fault(m);
		end
		wrap_up();
	end
	initial begin
		#(25 * 60000);
		failures++;
		wrap_up();
	end
endmodule
`default_nettype wire
